//--- inc/mau_pkg.sv
package mau_pkg;

  // ==========================================================
  // widths and sizes
  localparam int GPR_W    = 32;
  localparam int FPR_W    = 64;
  localparam int BUS_W    = 32;
  localparam int IMM_W    = 16;
  localparam int NREG     = 32;
  localparam int AQ_DEPTH = 4;
  localparam int CNT_W    = 8;

  localparam logic [CNT_W-1:0] BYTES_1 = 8'h01;
  localparam logic [CNT_W-1:0] BYTES_2 = 8'h02;
  localparam logic [CNT_W-1:0] BYTES_4 = 8'h04;
  localparam logic [CNT_W-1:0] BYTES_8 = 8'h08;
  localparam logic [4:0]       LAST_REG = 5'h1F;
  localparam logic [2:0]       LANES    = 3'h4;
  localparam logic [3:0]       ALL_BE   = 4'hF;

  // ==========================================================
  // instruction classes and access sizes
  typedef enum logic [2:0] {
    OP_LOAD  = 3'h0,
    OP_STORE = 3'h1,
    OP_LDM   = 3'h2,
    OP_STM   = 3'h3,
    OP_LDS   = 3'h4,
    OP_STS   = 3'h5,
    OP_SYNC  = 3'h6,
    OP_MTSPR = 3'h7
  } mau_op_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } mau_sz_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    mau_op_t          op;
    logic             fp;
    logic             dbl;
    mau_sz_t          sz;
    logic             upd;
    logic             use_imm;
    logic             ra_zero;
    logic             resv;
    logic [4:0]       rd;
    logic [4:0]       ra;
    logic [4:0]       rb;
    logic [IMM_W-1:0] imm;
    logic [CNT_W-1:0] cnt;
  } mau_ins_t;

  typedef struct packed {
    mau_op_t          op;
    logic             fp;
    logic             dbl;
    mau_sz_t          sz;
    logic [4:0]       rd;
    logic [BUS_W-1:0] addr;
    logic [CNT_W-1:0] bytes;
  } mau_aq_t;

  typedef struct packed {
    logic             wr;
    logic [BUS_W-1:0] addr;
    logic [3:0]       be;
    logic [BUS_W-1:0] wdata;
  } mau_bus_t;

  typedef struct packed {
    logic             we;
    logic             fp;
    logic [4:0]       idx;
    logic [FPR_W-1:0] data;
  } mau_wb_t;

endpackage

//--- core/mau_fifo.sv
module mau_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] rdata_o,
  output logic                  empty_o,
  output logic                  afull_o
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // parameter check
  if (DEPTH < 2 || DEPTH != (1 << AW))
  begin : g_bad
    $error("mau_fifo depth must be a power of two, at least 2");
  end

  // ==========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wptr;
  logic [AW:0]      rptr;
  logic [AW:0]      used;

  assign used    = wptr - rptr;
  assign empty_o = (used == '0);
  assign afull_o = (used >= (AW+1)'(DEPTH - 1));

  always_ff @(posedge clock_i)
  begin
    if (push_i)
    begin
      mem[wptr[AW-1:0]] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      wptr <= '0;
      rptr <= '0;
    end
    else
    begin
      if (push_i)
      begin
        wptr <= wptr + 1'b1;
      end
      if (pop_i)
      begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  // registered read port
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      rdata_o <= '0;
    end
    else if (pop_i)
    begin
      rdata_o <= mem[rptr[AW-1:0]];
    end
  end

endmodule

//--- core/mau_sb_check.sv
module mau_sb_check (
  input  wire logic              [mau_pkg::NREG-1:0] gpr_busy_i,
  input  wire logic              [mau_pkg::NREG-1:0] fpr_busy_i,
  input  wire mau_pkg::mau_ins_t                     ins_i,
  output logic                                       free_o
);

  // ==========================================================
  // registers the instruction needs
  logic [mau_pkg::NREG-1:0] gneed;
  logic [mau_pkg::NREG-1:0] fneed;

  always_comb
  begin
    gneed = '0;
    fneed = '0;
    if (!ins_i.ra_zero || ins_i.upd)
    begin
      gneed[ins_i.ra] = 1'b1;
    end
    if (!ins_i.use_imm)
    begin
      gneed[ins_i.rb] = 1'b1;
    end
    unique case (ins_i.op)
      mau_pkg::OP_LOAD, mau_pkg::OP_STORE:
      begin
        if (ins_i.fp)
        begin
          fneed[ins_i.rd] = 1'b1;
        end
        else
        begin
          gneed[ins_i.rd] = 1'b1;
        end
      end
      mau_pkg::OP_LDM, mau_pkg::OP_STM, mau_pkg::OP_LDS,
      mau_pkg::OP_STS:
      begin
        gneed = gneed | ({mau_pkg::NREG{1'b1}} << ins_i.rd);
      end
      mau_pkg::OP_MTSPR:
      begin
        gneed[ins_i.rd] = 1'b1;
      end
      mau_pkg::OP_SYNC:
      begin
        fneed = '0;
      end
    endcase
  end

  assign free_o = ~(|(gneed & gpr_busy_i)) & ~(|(fneed & fpr_busy_i));

endmodule

//--- core/mau_memory_access_unit.sv
// Contract
// - accept memory instructions of any size on consecutive cycles
// - 32-bit integer register path, 64-bit floating register path
// - single word internal access: one bus clock, two clocks latency
// - double word split into two 32-bit bus accesses
// - address is ra or zero plus rb or 16-bit immediate
// - check scoreboard for address, data and update registers first
// - on free operands take, release sequencer, ask integer unit
// - memory instructions execute and terminate in program order
// - empty address queue and idle bus engine: straight to bus; else queue address, data
// - update register written the clock after acceptance
// - store waits until all earlier instructions ended cleanly
// - one idle clock between load bus end and store bus start
// - synchronizing instructions taken only when earlier ones ended
// - issue stalls until synchronizing memory instruction ends; OP_MTSPR does not stall issue
// - single loads and stores follow parked zero-wait timings
// - double loads and stores follow their timings, halves pipelined
// - load multiple of N takes 1+N internal clocks
// - strings split into aligned partial and whole word accesses
// - load then two float stores: second store delayed one clock
// - memory stalls do not stall issue without data dependency
module mau_memory_access_unit (
  input  wire logic                               clock_i,
  input  wire logic                               resetn_i,
  input  wire logic                               ins_valid_i,
  input  wire mau_pkg::mau_ins_t                  ins_i,
  input  wire logic             [mau_pkg::NREG-1:0] gpr_busy_i,
  input  wire logic             [mau_pkg::NREG-1:0] fpr_busy_i,
  input  wire logic            [mau_pkg::GPR_W-1:0] gpr_a_i,
  input  wire logic            [mau_pkg::GPR_W-1:0] gpr_b_i,
  input  wire logic            [mau_pkg::GPR_W-1:0] gpr_s_i,
  input  wire logic            [mau_pkg::FPR_W-1:0] fpr_s_i,
  input  wire logic                               prior_clean_i,
  input  wire logic            [mau_pkg::BUS_W-1:0] ea_i,
  input  wire logic            [mau_pkg::GPR_W-1:0] mv_data_i,
  input  wire logic                               bus_ack_i,
  input  wire logic            [mau_pkg::BUS_W-1:0] bus_rdata_i,
  output logic                                    take_o,
  output logic                                    stall_issue_o,
  output logic                                    ea_req_o,
  output logic                 [mau_pkg::BUS_W-1:0] ea_a_o,
  output logic                 [mau_pkg::BUS_W-1:0] ea_b_o,
  output mau_pkg::mau_wb_t                        upd_o,
  output mau_pkg::mau_wb_t                        ld_o,
  output logic                                    bus_req_o,
  output mau_pkg::mau_bus_t                       bus_o,
  output logic                                    [4:0] mv_idx_o
);

  localparam int AQ_W = $bits(mau_pkg::mau_aq_t);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN   = 2'b11
  } mau_state_t;

  // ==========================================================
  // declarations
  mau_state_t           state;
  mau_pkg::mau_ins_t    s1_ins;
  logic                 s1_v;
  logic [63:0]          s1_sd;
  mau_pkg::mau_aq_t     e1;
  mau_pkg::mau_aq_t     cur;
  mau_pkg::mau_aq_t     next_cur;
  mau_pkg::mau_aq_t     aq_rd;
  logic [63:0]          cur_sd;
  logic [63:0]          next_sd;
  logic [63:0]          sdq_rd;
  logic [7:0]           rem;
  logic [7:0]           widx;
  logic [7:0]           b_widx;
  logic [7:0]           n;
  logic [7:0]           next_widx;
  logic [31:0]          baddr;
  logic [1:0]           b_off;
  logic [3:0]           be;
  logic [31:0]          wdata;
  logic [31:0]          dhi;
  logic                 sb_free;
  logic                 sync_op;
  logic                 hold_op;
  logic                 unit_empty;
  logic                 rej;
  logic                 acc;
  logic                 aq_empty;
  logic                 aq_afull;
  logic                 sdq_afull;
  logic                 byp;
  logic                 aq_push;
  logic                 aq_pop;
  logic                 sd_push;
  logic                 sd_pop;
  logic                 load_cur;
  logic                 cur_wr;
  logic                 beat_done;
  logic                 rd_done;
  logic                 launch;
  logic                 done;

  function automatic logic [7:0] op_bytes(mau_pkg::mau_ins_t i);
    logic [7:0] r;
    r = '0;
    unique case (i.op)
      mau_pkg::OP_LOAD, mau_pkg::OP_STORE:
      begin
        if (i.dbl)
        begin
          r = mau_pkg::BYTES_8;
        end
        else if (i.sz == mau_pkg::SZ_BYTE)
        begin
          r = mau_pkg::BYTES_1;
        end
        else if (i.sz == mau_pkg::SZ_HALF)
        begin
          r = mau_pkg::BYTES_2;
        end
        else
        begin
          r = mau_pkg::BYTES_4;
        end
      end
      mau_pkg::OP_LDM, mau_pkg::OP_STM:
      begin
        r = 8'((8'(mau_pkg::LAST_REG - i.rd) + 8'h01) << 2);
      end
      mau_pkg::OP_LDS, mau_pkg::OP_STS:
      begin
        r = i.cnt;
      end
      mau_pkg::OP_MTSPR:
      begin
        r = mau_pkg::BYTES_4;
      end
      mau_pkg::OP_SYNC:
      begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // ==========================================================
  // acceptance
  // scoreboard operand check
  mau_sb_check u_sb (
    .gpr_busy_i (gpr_busy_i),
    .fpr_busy_i (fpr_busy_i),
    .ins_i      (ins_i),
    .free_o     (sb_free)
  );

  assign sync_op = ins_i.resv || ins_i.op inside {mau_pkg::OP_LDM,
    mau_pkg::OP_STM, mau_pkg::OP_LDS, mau_pkg::OP_STS,
    mau_pkg::OP_SYNC, mau_pkg::OP_MTSPR};
  assign hold_op = sync_op && ins_i.op != mau_pkg::OP_MTSPR;
  assign unit_empty = !s1_v && state == ST_IDLE && aq_empty;

  assign acc = ins_valid_i && !rej && sb_free && !aq_afull
    && !sdq_afull && !stall_issue_o
    && (!sync_op || (unit_empty && prior_clean_i));

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      take_o   <= 1'b0;
      rej      <= 1'b0;
      ea_req_o <= 1'b0;
      ea_a_o   <= '0;
      ea_b_o   <= '0;
    end
    else
    begin
      take_o   <= acc;
      rej      <= ins_valid_i && !acc;
      ea_req_o <= acc;
      ea_a_o   <= ins_i.ra_zero ? '0 : gpr_a_i;
      ea_b_o   <= ins_i.use_imm ? 32'(signed'(ins_i.imm)) : gpr_b_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      stall_issue_o <= 1'b0;
    end
    else if (acc && hold_op)
    begin
      stall_issue_o <= 1'b1;
    end
    else if (done)
    begin
      stall_issue_o <= 1'b0;
    end
  end

  // ==========================================================
  // address stage
  // 32-bit and 64-bit data paths
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      s1_v   <= 1'b0;
      s1_ins <= '0;
      s1_sd  <= '0;
    end
    else
    begin
      s1_v   <= acc;
      s1_ins <= ins_i;
      s1_sd  <= ins_i.fp ? fpr_s_i : {32'h0000_0000, gpr_s_i};
    end
  end

  always_comb
  begin
    e1       = '0;
    e1.op    = s1_ins.op;
    e1.fp    = s1_ins.fp;
    e1.dbl   = s1_ins.dbl;
    e1.sz    = s1_ins.sz;
    e1.rd    = s1_ins.rd;
    e1.addr  = ea_i;
    e1.bytes = op_bytes(s1_ins);
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      upd_o <= '0;
    end
    else
    begin
      upd_o.we   <= s1_v && s1_ins.upd;
      upd_o.fp   <= 1'b0;
      upd_o.idx  <= s1_ins.ra;
      upd_o.data <= {32'h0000_0000, ea_i};
    end
  end

  // ==========================================================
  // queues
  // bypass when queue empty and engine idle, else enqueue
  assign byp     = s1_v && state == ST_IDLE && aq_empty;
  assign aq_push = s1_v && !byp;
  assign sd_push = aq_push;
  assign aq_pop  = state == ST_IDLE && !aq_empty;
  assign sd_pop  = aq_pop;

  mau_fifo #(
    .WIDTH (AQ_W),
    .DEPTH (mau_pkg::AQ_DEPTH)
  ) u_aq (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .push_i   (aq_push),
    .wdata_i  (e1),
    .pop_i    (aq_pop),
    .rdata_o  (aq_rd),
    .empty_o  (aq_empty),
    .afull_o  (aq_afull)
  );

  mau_fifo #(
    .WIDTH (64),
    .DEPTH (mau_pkg::AQ_DEPTH)
  ) u_sdq (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .push_i   (sd_push),
    .wdata_i  (s1_sd),
    .pop_i    (sd_pop),
    .rdata_o  (sdq_rd),
    .empty_o  (),
    .afull_o  (sdq_afull)
  );

  // ==========================================================
  // bus engine
  assign load_cur = (state == ST_IDLE && byp) || state == ST_FETCH;
  assign next_cur = (state == ST_FETCH) ? aq_rd : e1;
  assign next_sd  = (state == ST_FETCH) ? sdq_rd : s1_sd;
  assign cur_wr   = cur.op inside {mau_pkg::OP_STORE, mau_pkg::OP_STM,
    mau_pkg::OP_STS, mau_pkg::OP_MTSPR};
  assign beat_done = bus_req_o && bus_ack_i;
  assign rd_done   = beat_done && !bus_o.wr;

  // aligned pieces of at most one word
  always_comb
  begin
    n  = 8'(mau_pkg::LANES - {1'b0, baddr[1:0]});
    if (rem < n)
    begin
      n = rem;
    end
    be = 4'(mau_pkg::ALL_BE << (mau_pkg::LANES - n[2:0])) >> baddr[1:0];
    next_widx = widx + n;
  end

  always_comb
  begin
    wdata = mv_data_i;
    if (cur.op inside {mau_pkg::OP_STORE, mau_pkg::OP_MTSPR})
    begin
      if (cur.dbl)
      begin
        wdata = (widx == '0) ? cur_sd[63:32] : cur_sd[31:0];
      end
      else if (cur.sz == mau_pkg::SZ_BYTE)
      begin
        wdata = {4{cur_sd[7:0]}};
      end
      else if (cur.sz == mau_pkg::SZ_HALF)
      begin
        wdata = {2{cur_sd[15:0]}};
      end
      else
      begin
        wdata = cur_sd[31:0];
      end
    end
  end

  assign launch = state == ST_RUN && rem != '0
    && (!bus_req_o || bus_ack_i)
    && (!cur_wr || (prior_clean_i && !rd_done));
  assign done = state == ST_RUN && rem == '0
    && (!bus_req_o || bus_ack_i);

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (aq_pop)
          begin
            state <= ST_FETCH;
          end
          else if (byp)
          begin
            state <= ST_RUN;
          end
        end
        ST_FETCH:
        begin
          state <= ST_RUN;
        end
        ST_RUN:
        begin
          if (done)
          begin
            state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      cur      <= '0;
      cur_sd   <= '0;
      rem      <= '0;
      widx     <= '0;
      baddr    <= '0;
      mv_idx_o <= '0;
    end
    else if (load_cur)
    begin
      cur      <= next_cur;
      cur_sd   <= next_sd;
      rem      <= next_cur.bytes;
      widx     <= '0;
      baddr    <= next_cur.addr;
      mv_idx_o <= next_cur.rd;
    end
    else if (launch)
    begin
      rem      <= rem - n;
      widx     <= next_widx;
      baddr    <= baddr + 32'(n);
      mv_idx_o <= cur.rd + 5'(next_widx[6:2]);
    end
  end

  // one bus clock per word, back to back
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      bus_req_o <= 1'b0;
      bus_o     <= '0;
      b_off     <= '0;
      b_widx    <= '0;
    end
    else if (launch)
    begin
      bus_req_o   <= 1'b1;
      bus_o.wr    <= cur_wr;
      bus_o.addr  <= {baddr[31:2], 2'b00};
      bus_o.be    <= be;
      bus_o.wdata <= wdata;
      b_off       <= baddr[1:0];
      b_widx      <= widx;
    end
    else if (bus_ack_i)
    begin
      bus_req_o <= 1'b0;
    end
  end

  // ==========================================================
  // load writeback
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      ld_o <= '0;
      dhi  <= '0;
    end
    else
    begin
      ld_o.we  <= rd_done && !(cur.dbl && b_widx == '0);
      ld_o.fp  <= cur.fp;
      ld_o.idx <= (cur.op == mau_pkg::OP_LOAD) ? cur.rd
        : cur.rd + 5'(b_widx[6:2]);
      if (rd_done && cur.dbl && b_widx == '0)
      begin
        dhi <= bus_rdata_i;
      end
      if (cur.dbl)
      begin
        ld_o.data <= {dhi, bus_rdata_i};
      end
      else if (cur.op == mau_pkg::OP_LOAD
        && cur.sz == mau_pkg::SZ_BYTE)
      begin
        ld_o.data <= 64'(8'(bus_rdata_i >> {~b_off, 3'b000}));
      end
      else if (cur.op == mau_pkg::OP_LOAD
        && cur.sz == mau_pkg::SZ_HALF)
      begin
        ld_o.data <= 64'(16'(bus_rdata_i >> {~b_off[1], 4'h0}));
      end
      else
      begin
        ld_o.data <= {32'h0000_0000, bus_rdata_i};
      end
    end
  end

endmodule

//--- dv/mau_mem_model.sv
module mau_mem_model (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic              bus_req_i,
  input  wire mau_pkg::mau_bus_t bus_i,
  input  wire logic [1:0]        waits_i,
  output logic                   ack_o,
  output logic [31:0]            rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] wait_cnt;

  // ==========================================================
  // beat answer
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i || !bus_req_i || ack_o)
      wait_cnt <= 2'h0;
    else
      wait_cnt <= wait_cnt + 2'h1;
  end

  assign ack_o   = bus_req_i && (wait_cnt == waits_i);
  assign rdata_o = ack_o ? {bus_i.addr[15:0], ~bus_i.addr[15:0]}
                         : {~bus_i.addr[15:0], bus_i.addr[15:0]};
endmodule

//--- dv/mau_unit_props.sv
module mau_unit_props (
  input wire logic                       clock_i,
  input wire logic                       resetn_i,
  input wire logic                       ins_valid_i,
  input wire mau_pkg::mau_ins_t          ins_i,
  input wire logic [mau_pkg::NREG-1:0]   gpr_busy_i,
  input wire logic [mau_pkg::GPR_W-1:0]  gpr_a_i,
  input wire logic [mau_pkg::GPR_W-1:0]  gpr_b_i,
  input wire logic                       prior_clean_i,
  input wire logic [mau_pkg::BUS_W-1:0]  ea_i,
  input wire logic                       bus_ack_i,
  input wire logic                       take_o,
  input wire logic                       stall_issue_o,
  input wire logic                       ea_req_o,
  input wire logic [mau_pkg::BUS_W-1:0]  ea_a_o,
  input wire logic [mau_pkg::BUS_W-1:0]  ea_b_o,
  input wire mau_pkg::mau_wb_t           upd_o,
  input wire mau_pkg::mau_wb_t           ld_o,
  input wire logic                       bus_req_o,
  input wire mau_pkg::mau_bus_t          bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] imm_ext;

  assign imm_ext = {{16{ins_i.imm[15]}}, ins_i.imm};

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // sequences
  sequence upd_taken;
    take_o && $past(ins_i.upd);
  endsequence

  sequence read_done;
    bus_req_o && bus_ack_i && !bus_o.wr;
  endsequence

  // ==========================================================
  // assertions
  take_ea_a:
    assert property (take_o |-> ea_req_o) else $error("take without ea");
  take_free_a:
    assert property (take_o |-> $past(ins_valid_i &&
      (ins_i.ra_zero || !gpr_busy_i[ins_i.ra]))) else $error("busy taken");
  ea_base_a:
    assert property (ea_req_o |-> ea_a_o ==
      ($past(ins_i.ra_zero) ? 32'h0 : $past(gpr_a_i))) else $error("ea a");
  ea_offset_a:
    assert property (ea_req_o |-> ea_b_o ==
      ($past(ins_i.use_imm) ? $past(imm_ext) : $past(gpr_b_i)))
      else $error("ea b");
  upd_next_a:
    assert property (upd_taken |=> upd_o.we && upd_o.idx == $past(ins_i.ra, 2)
      && upd_o.data[31:0] == $past(ea_i)) else $error("update late");
  store_clean_a:
    assert property ($rose(bus_req_o) && bus_o.wr |-> $past(prior_clean_i))
      else $error("store before clean");
  load_gap_a:
    assert property (read_done |=> !(bus_req_o && bus_o.wr))
      else $error("no idle after load");
  beat_hold_a:
    assert property (bus_req_o && !bus_ack_i |=> bus_req_o && $stable(bus_o))
      else $error("beat dropped");
  ld_after_ack_a:
    assert property (ld_o.we |-> $past(bus_req_o && bus_ack_i && !bus_o.wr))
      else $error("load result early");
  sync_block_a:
    assert property (stall_issue_o |=> !take_o) else $error("taken in stall");
  sync_clean_a:
    assert property (take_o && $past(ins_i.op[2:1] != 2'h0 || ins_i.resv)
      |-> $past(prior_clean_i)) else $error("sync taken early");
  word_align_a:
    assert property (bus_req_o |-> bus_o.addr[1:0] == 2'h0)
      else $error("unaligned beat");
endmodule

bind mau_memory_access_unit mau_unit_props mau_unit_props_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .ins_valid_i(ins_valid_i),
  .ins_i(ins_i), .gpr_busy_i(gpr_busy_i), .gpr_a_i(gpr_a_i),
  .gpr_b_i(gpr_b_i), .prior_clean_i(prior_clean_i), .ea_i(ea_i),
  .bus_ack_i(bus_ack_i), .take_o(take_o), .stall_issue_o(stall_issue_o),
  .ea_req_o(ea_req_o), .ea_a_o(ea_a_o), .ea_b_o(ea_b_o), .upd_o(upd_o),
  .ld_o(ld_o), .bus_req_o(bus_req_o), .bus_o(bus_o));

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock_i = 1'b0;
  logic              resetn_i = 1'b0;
  logic              ins_valid_i = 1'b0;
  logic              prior_clean_i = 1'b1;
  mau_pkg::mau_ins_t ins_i = '0;
  logic [31:0]       gpr_busy_i = '0, fpr_busy_i = '0, gpr_s_i = '0;
  logic [31:0]       gpr_a_i = '0, gpr_b_i = '0;
  logic [63:0]       fpr_s_i = '0;
  logic [31:0]       ea_i, mv_data_i, bus_rdata_i, ea_a_o, ea_b_o;
  logic              bus_ack_i, take_o, stall_issue_o, ea_req_o, bus_req_o;
  logic [4:0]        mv_idx_o;
  logic [1:0]        waits = 2'h0;
  mau_pkg::mau_wb_t  upd_o, ld_o, ew;
  mau_pkg::mau_bus_t bus_o, eb;
  mau_pkg::mau_bus_t bus_q[$];
  mau_pkg::mau_wb_t  ld_q[$];
  logic [36:0]       upd_q[$];
  int                err_count = 0, checks_done = 0, cycles = 0;

  always #12.5 clock_i = ~clock_i;

  // integer unit and register file stand-ins
  assign ea_i = ea_req_o ? ea_a_o + ea_b_o : ~(ea_a_o + ea_b_o);
  assign mv_data_i = {27'h0, mv_idx_o} ^ 32'h5A5A0000;

  mau_memory_access_unit mau_memory_access_unit_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .ins_valid_i(ins_valid_i),
    .ins_i(ins_i), .gpr_busy_i(gpr_busy_i), .fpr_busy_i(fpr_busy_i),
    .gpr_a_i(gpr_a_i), .gpr_b_i(gpr_b_i), .gpr_s_i(gpr_s_i),
    .fpr_s_i(fpr_s_i), .prior_clean_i(prior_clean_i), .ea_i(ea_i),
    .mv_data_i(mv_data_i), .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i),
    .take_o(take_o), .stall_issue_o(stall_issue_o), .ea_req_o(ea_req_o),
    .ea_a_o(ea_a_o), .ea_b_o(ea_b_o), .upd_o(upd_o), .ld_o(ld_o),
    .bus_req_o(bus_req_o), .bus_o(bus_o), .mv_idx_o(mv_idx_o));

  mau_mem_model mau_mem_model_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .bus_req_i(bus_req_o),
    .bus_i(bus_o), .waits_i(waits), .ack_o(bus_ack_i),
    .rdata_o(bus_rdata_i));

  // ==========================================================
  // helpers
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  function automatic mau_pkg::mau_ins_t mk(mau_pkg::mau_op_t op, logic fp,
                                           logic dbl, logic upd,
                                           logic [4:0] rd);
    return '{op, fp, dbl, mau_pkg::SZ_WORD, upd, 1'($urandom), 1'b0, 1'b0,
             rd, 5'h03, 5'h04, 16'($urandom) & 16'hFFFC, 8'h00};
  endfunction

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // expected beats and results of a taken instruction
  task automatic expect_ops(mau_pkg::mau_ins_t i);
    logic [31:0] ea;
    int          n;
    mau_pkg::mau_bus_t b;
    ea = gpr_a_i + (i.use_imm ? {{16{i.imm[15]}}, i.imm} : gpr_b_i);
    if (i.upd)
      upd_q.push_back({i.ra, ea});
    n = (i.op == mau_pkg::OP_LDM) ? 32 - i.rd : (i.dbl ? 2 : 1);
    for (int k = 0; k < n; k++)
    begin
      b.wr = (i.op == mau_pkg::OP_STORE);
      b.addr = ea + 4 * k;
      b.be = mau_pkg::ALL_BE;
      b.wdata = i.fp ? (k ? fpr_s_i[31:0] : fpr_s_i[63:32]) : gpr_s_i;
      bus_q.push_back(b);
      if (!b.wr && !i.dbl)
        ld_q.push_back({1'b1, i.fp, i.rd + 5'(k), {32'h0, pat(b.addr)}});
    end
    if (!b.wr && i.dbl)
      ld_q.push_back({1'b1, 1'b1, i.rd, pat(ea), pat(ea + 4)});
  endtask

  task automatic issue(mau_pkg::mau_ins_t i);
    repeat (60)
    begin
      ins_i = i;
      ins_valid_i = 1'b1;
      @(posedge clock_i);
      #2;
      if (take_o === 1'b1)
      begin
        expect_ops(i);
        return;
      end
      ins_valid_i = 1'b0;
      @(posedge clock_i);
      #2;
    end
    check("take", 1'b0, 1'b1);
  endtask

  task automatic rnd(mau_pkg::mau_op_t op, logic fp, logic dbl, logic upd,
                     logic [4:0] rd);
    gpr_a_i = $urandom & 32'hFFFC;
    gpr_b_i = $urandom & 32'h0FFC;
    gpr_s_i = $urandom;
    fpr_s_i = {$urandom, $urandom};
    issue(mk(op, fp, dbl, upd, rd));
  endtask

  task automatic idle(int n);
    ins_valid_i = 1'b0;
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  // ==========================================================
  // result monitor
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict;
    end
    if (resetn_i && bus_req_o && bus_ack_i)
    begin
      eb = bus_q.pop_front();
      check("beat", {bus_o.wr, bus_o.be, bus_o.addr},
            {eb.wr, eb.be, eb.addr});
      if (eb.wr)
        check("wdata", bus_o.wdata, eb.wdata);
    end
    if (resetn_i && ld_o.we)
    begin
      ew = ld_q.pop_front();
      check("load", {ld_o.fp, ld_o.idx, ld_o.data},
            {ew.fp, ew.idx, ew.data});
    end
    if (resetn_i && upd_o.we)
      check("update", {upd_o.idx, upd_o.data[31:0]},
            upd_q.pop_front());
  end

  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'hB837));
    repeat (12) @(posedge clock_i);
    #2;
    resetn_i = 1'b1;
    gpr_busy_i = 32'h00000008;
    ins_i = mk(mau_pkg::OP_LOAD, 1'b0, 1'b0, 1'b0, 5'h08);
    ins_valid_i = 1'b1;
    @(posedge clock_i);
    #2;
    check("busy take", take_o, 1'b0);
    gpr_busy_i = '0;
    for (int p = 0; p < 2; p++)
    begin
      waits = p ? 2'($urandom_range(2)) : 2'h0;
      gpr_busy_i = $urandom & 32'h000000E0;
      fpr_busy_i = $urandom & 32'h000000E0;
      rnd(mau_pkg::OP_LOAD, 1'b0, 1'b0, 1'b0, 5'h08);
      rnd(mau_pkg::OP_LOAD, 1'b0, 1'b0, 1'b1, 5'h09);
      rnd(mau_pkg::OP_STORE, 1'b0, 1'b0, 1'b0, 5'h0A);
      rnd(mau_pkg::OP_LOAD, 1'b1, 1'b1, 1'b0, 5'h0B);
      rnd(mau_pkg::OP_STORE, 1'b1, 1'b1, 1'b0, 5'h0C);
      idle(40);
      prior_clean_i = 1'b0;
      rnd(mau_pkg::OP_STORE, 1'b0, 1'b0, 1'b0, 5'h0D);
      idle(6);
      check("held store", bus_req_o, 1'b0);
      prior_clean_i = 1'b1;
      rnd(mau_pkg::OP_LDM, 1'b0, 1'b0, 1'b0, 5'h1D);
      idle(1);
      check("stall", stall_issue_o, 1'b1);
      rnd(mau_pkg::OP_LOAD, 1'b0, 1'b0, 1'b0, 5'h0E);
      idle(40);
    end
    check("drained", bus_q.size() + ld_q.size(), 0);
    print_verdict;
  end
endmodule
